//--- shared/dram_dp_defs.svh
`ifndef DRAM_DP_DEFS_SVH
`define DRAM_DP_DEFS_SVH

// clock rate and initialization timing
`define DP_CLK_MHZ 10
`define DP_INIT_TIME_NS 200000
`define DP_INIT_CYCLES ((`DP_INIT_TIME_NS * `DP_CLK_MHZ + 999) / 1000)
`define DP_INIT_MIN 16
`define DP_INIT_MAX 80000

// mode word field positions
`define DP_MR_CFG_LSB 0
`define DP_MR_BL_LSB 3
`define DP_MR_DLL_BIT 7
`define DP_MR_IMP_BIT 8
`define DP_MR_ODT_BIT 9

// burst length codes
`define DP_BL2_CODE 2'h0
`define DP_BL4_CODE 2'h1
`define DP_BL8_CODE 2'h2

`endif

//--- shared/dram_dp_pkg.sv
package dram_dp_pkg;
	typedef enum logic [1:0] {
		ST_WAIT,
		ST_MRS,
		ST_RUN
	} init_state_e;
endpackage : dram_dp_pkg

//--- logic/dp_pin_sync.sv
`timescale 1ns/1ps
module dp_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s r;
	sync_s n;

	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign q = r.s2;
endmodule : dp_pin_sync

//--- logic/low_latency_dram_datapath.sv
`timescale 1ns/1ps
`include "dram_dp_defs.svh"
module low_latency_dram_datapath import dram_dp_pkg::*; #(
	parameter int DATA_W = 18,
	parameter int GROUP_W = 9,
	parameter int DEVICES = 1,
	parameter int ADDR_W = 20,
	parameter int CLK_PAIRS = 1,
	parameter int CMD_BUSES = 1,
	parameter int BURST_LEN = 4,
	parameter int MEM_CONFIG = 1,
	parameter int ODT_EN = 0,
	parameter int IMP_EN = 0,
	parameter int DLL_EN = 1,
	parameter int SHARED_IO = 1,
	parameter int STROBE_MODE = 1,
	parameter int GEN_MASK = 1,
	parameter int INIT_CYCLES = `DP_INIT_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// controller side
	input wire logic [ADDR_W-1:0] ctl_addr,
	input wire logic [2:0] ctl_bank,
	input wire logic ctl_cs_n,
	input wire logic ctl_we_n,
	input wire logic ctl_ref_n,
	input wire logic ctl_doing_wr,
	input wire logic ctl_wdata_valid,
	input wire logic [2*DATA_W-1:0] ctl_wdata,
	input wire logic [2*DEVICES-1:0] ctl_write_mask,
	// user status and read data
	output logic init_done,
	output logic [2*DATA_W-1:0] rdata,
	output logic [DEVICES-1:0] rdata_valid,
	output logic read_burst_end,
	// memory clocks
	output logic [CLK_PAIRS-1:0] mem_clk,
	output logic [CLK_PAIRS-1:0] mem_clk_n,
	// command bus 0
	output logic [ADDR_W-1:0] mem_addr_0,
	output logic [2:0] mem_bank_0,
	output logic mem_cs_n_0,
	output logic mem_we_n_0,
	output logic mem_ref_n_0,
	// command bus 1
	output logic [ADDR_W-1:0] mem_addr_1,
	output logic [2:0] mem_bank_1,
	output logic mem_cs_n_1,
	output logic mem_we_n_1,
	output logic mem_ref_n_1,
	// shared data bus
	input wire logic [DATA_W-1:0] mem_dq_in,
	output logic [DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe,
	// split data buses
	input wire logic [DATA_W-1:0] mem_q,
	output logic [DATA_W-1:0] mem_d,
	output logic mem_d_oe,
	// strobes, valid flag, mask
	input wire logic [DATA_W/GROUP_W-1:0] mem_read_strobe_in,
	output logic [DATA_W/GROUP_W-1:0] mem_read_strobe_out,
	output logic mem_read_strobe_oe,
	input wire logic [DEVICES-1:0] mem_read_valid,
	output logic [DEVICES-1:0] mem_write_mask
);
	localparam int STROBES = DATA_W / GROUP_W;
	localparam int SPD = STROBES / DEVICES;
	localparam int BUSES = (DEVICES == 1) ? 1 : CMD_BUSES;
	localparam int LOCAL_BEATS = BURST_LEN / 2;
	localparam int INIT_N = (INIT_CYCLES < `DP_INIT_MIN) ? `DP_INIT_MIN :
		((INIT_CYCLES > `DP_INIT_MAX) ? `DP_INIT_MAX : INIT_CYCLES);

	typedef struct packed {
		logic ph;
		init_state_e st;
		logic [16:0] init_cnt;
		logic done;
		logic [CLK_PAIRS-1:0] mclk;
		logic [CLK_PAIRS-1:0] mclk_n;
		logic [ADDR_W-1:0] a0;
		logic [2:0] ba0;
		logic cs0_n;
		logic we0_n;
		logic ref0_n;
		logic [ADDR_W-1:0] a1;
		logic [2:0] ba1;
		logic cs1_n;
		logic we1_n;
		logic ref1_n;
		logic [2*DATA_W-1:0] wd;
		logic [2*DEVICES-1:0] wm;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
		logic [DATA_W-1:0] d_out;
		logic d_oe;
		logic [DEVICES-1:0] mask;
		logic [STROBES-1:0] kprev;
		logic [DATA_W-1:0] rd_lo;
		logic [2*DATA_W-1:0] rdata;
		logic [DEVICES-1:0] rvalid;
		logic [1:0] rd_cnt;
		logic burst_end;
	} dp_state_s;

	dp_state_s r;
	dp_state_s n;
	logic [DATA_W-1:0] qs;
	logic [STROBES-1:0] ks;
	logic [DEVICES-1:0] vs;

	// mode word built from build options
	function automatic logic [ADDR_W-1:0] mode_word();
		logic [ADDR_W-1:0] w;
		w = '0;
		w[`DP_MR_CFG_LSB +: 3] = 3'(MEM_CONFIG);
		w[`DP_MR_BL_LSB +: 2] = (BURST_LEN == 8) ? `DP_BL8_CODE :
			((BURST_LEN == 4) ? `DP_BL4_CODE : `DP_BL2_CODE);
		w[`DP_MR_DLL_BIT] = (DLL_EN != 0);
		w[`DP_MR_IMP_BIT] = (IMP_EN != 0);
		w[`DP_MR_ODT_BIT] = (ODT_EN != 0);
		return w;
	endfunction : mode_word

	// pin synchronisers
	dp_pin_sync #(.W(DATA_W)) u_data_sync (
		.clock(clock),
		.nrst(nrst),
		.d((SHARED_IO != 0) ? mem_dq_in : mem_q),
		.q(qs)
	);
	dp_pin_sync #(.W(STROBES)) u_strobe_sync (
		.clock(clock),
		.nrst(nrst),
		.d(mem_read_strobe_in),
		.q(ks)
	);
	dp_pin_sync #(.W(DEVICES)) u_valid_sync (
		.clock(clock),
		.nrst(nrst),
		.d(mem_read_valid),
		.q(vs)
	);

	always_comb begin
		logic [DATA_W-1:0] beat;
		logic [STROBES-1:0] rise_v;
		logic [STROBES-1:0] fall_v;
		logic load;
		logic [ADDR_W-1:0] c_a;
		logic [2:0] c_ba;
		logic c_cs;
		logic c_we;
		logic c_ref;
		beat = '0;
		rise_v = '0;
		fall_v = '0;
		load = 1'b0;
		c_a = '0;
		c_ba = '0;
		c_cs = 1'b1;
		c_we = 1'b1;
		c_ref = 1'b1;
		n = r;
		// memory clock divider
		n.ph = ~r.ph;
		n.mclk = {CLK_PAIRS{~r.ph}};
		n.mclk_n = {CLK_PAIRS{r.ph}};
		n.burst_end = 1'b0;
		// write data and mask holding
		if (ctl_wdata_valid) begin
			n.wd = ctl_wdata;
			if (GEN_MASK != 0) begin
				n.wm = ctl_write_mask;
			end
		end
		// first beat while clock high, second while low
		beat = r.ph ? r.wd[2*DATA_W-1:DATA_W] : r.wd[DATA_W-1:0];
		n.dq_oe = ctl_doing_wr && (SHARED_IO != 0);
		n.d_oe = ctl_doing_wr && (SHARED_IO == 0);
		n.dq_out = (SHARED_IO != 0) ? beat : '0;
		n.d_out = (SHARED_IO == 0) ? beat : '0;
		for (int d = 0; d < DEVICES; d++) begin
			n.mask[d] = (GEN_MASK != 0) && (r.ph ? r.wm[2*d+1] : r.wm[2*d]);
		end
		// initialization and command issue
		case (r.st)
			ST_WAIT: begin
				if (r.init_cnt == 17'(INIT_N - 1)) begin
					n.st = ST_MRS;
				end else begin
					n.init_cnt = r.init_cnt + 17'h0_0001;
				end
			end
			ST_MRS: begin
				if (!r.ph) begin
					load = 1'b1;
					c_a = mode_word();
					c_cs = 1'b0;
					c_we = 1'b0;
					c_ref = 1'b0;
					n.st = ST_RUN;
				end
			end
			ST_RUN: begin
				n.done = 1'b1;
				if (!r.ph) begin
					load = 1'b1;
					c_a = ctl_addr;
					c_ba = ctl_bank;
					c_cs = ctl_cs_n;
					c_we = ctl_we_n;
					c_ref = ctl_ref_n;
				end
			end
			default: begin
				n.st = ST_WAIT;
			end
		endcase
		// commands change only at the rising memory clock
		if (load) begin
			n.a0 = c_a;
			n.ba0 = c_ba;
			n.cs0_n = c_cs;
			n.we0_n = c_we;
			n.ref0_n = c_ref;
			if (BUSES == 2) begin
				n.a1 = c_a;
				n.ba1 = c_ba;
				n.cs1_n = c_cs;
				n.we1_n = c_we;
				n.ref1_n = c_ref;
			end
		end
		// read capture per strobe group
		for (int g = 0; g < STROBES; g++) begin
			if (STROBE_MODE != 0) begin
				rise_v[g] = ks[g] && !r.kprev[g];
				fall_v[g] = !ks[g] && r.kprev[g];
			end else begin
				rise_v[g] = r.ph;
				fall_v[g] = !r.ph;
			end
			if (rise_v[g]) begin
				n.rd_lo[g*GROUP_W +: GROUP_W] = qs[g*GROUP_W +: GROUP_W];
			end
			if (fall_v[g]) begin
				n.rdata[g*GROUP_W +: GROUP_W] = r.rd_lo[g*GROUP_W +: GROUP_W];
				n.rdata[DATA_W + g*GROUP_W +: GROUP_W] = qs[g*GROUP_W +: GROUP_W];
			end
		end
		n.kprev = ks;
		for (int d = 0; d < DEVICES; d++) begin
			n.rvalid[d] = fall_v[d*SPD] && vs[d];
		end
		if (n.rvalid[0]) begin
			if (r.rd_cnt == 2'(LOCAL_BEATS - 1)) begin
				n.rd_cnt = 2'h0;
				n.burst_end = 1'b1;
			end else begin
				n.rd_cnt = r.rd_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.cs0_n <= 1'b1;
			r.we0_n <= 1'b1;
			r.ref0_n <= 1'b1;
			r.cs1_n <= 1'b1;
			r.we1_n <= 1'b1;
			r.ref1_n <= 1'b1;
			r.mclk_n <= '1;
		end else begin
			r <= n;
		end
	end

	assign init_done = r.done;
	assign rdata = r.rdata;
	assign rdata_valid = r.rvalid;
	assign read_burst_end = r.burst_end;
	assign mem_clk = r.mclk;
	assign mem_clk_n = r.mclk_n;
	assign mem_addr_0 = r.a0;
	assign mem_bank_0 = r.ba0;
	assign mem_cs_n_0 = r.cs0_n;
	assign mem_we_n_0 = r.we0_n;
	assign mem_ref_n_0 = r.ref0_n;
	assign mem_addr_1 = r.a1;
	assign mem_bank_1 = r.ba1;
	assign mem_cs_n_1 = r.cs1_n;
	assign mem_we_n_1 = r.we1_n;
	assign mem_ref_n_1 = r.ref1_n;
	assign mem_dq_out = r.dq_out;
	assign mem_dq_oe = r.dq_oe;
	assign mem_d = r.d_out;
	assign mem_d_oe = r.d_oe;
	assign mem_read_strobe_out = '0;
	assign mem_read_strobe_oe = 1'b0;
	assign mem_write_mask = r.mask;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	cmd_hold_a: assert property ($changed(r.cs0_n) |-> r.ph && $past(r.st) != ST_WAIT)
		else $error("command changed off the clock edge");
	wdata_hold_a: assert property (!ctl_wdata_valid |=> $stable(r.wd) && $stable(r.wm))
		else $error("write data register moved without valid");
	drive_en_a: assert property (r.dq_oe || r.d_oe |-> $past(ctl_doing_wr))
		else $error("write drivers on without doing write");
	bus_kind_a: assert property (!(r.dq_oe && r.d_oe))
		else $error("both data buses driven");
	strobe_idle_a: assert property (!mem_read_strobe_oe && mem_read_strobe_out == '0)
		else $error("strobe pin driven");
	init_wait_a: assert property (r.st == ST_WAIT |-> r.cs0_n && !r.done)
		else $error("command during initialization wait");
	init_end_a: assert property ($rose(r.done) |-> $past(r.init_cnt) == 17'(INIT_N - 1))
		else $error("init done before wait count");
	bus_two_a: assert property (BUSES == 1 |-> r.cs1_n && r.we1_n && r.ref1_n)
		else $error("second command bus active");
	rvalid_src_a: assert property (r.rvalid[0] |-> $past(vs[0]))
		else $error("read valid without memory flag");
	mask_off_a: assert property (GEN_MASK == 0 |-> r.mask == '0)
		else $error("mask driven while disabled");
	bank_load_a: assert property (r.st == ST_RUN && !r.ph |=> r.ba0 == $past(ctl_bank))
		else $error("bank not taken from controller");
endmodule : low_latency_dram_datapath

//--- testbench/mem_model.sv
`timescale 1ns/1ps
module mem_model (
	// clock
	input wire logic clock,
	// read side pins
	output logic [17:0] dq,
	output logic [17:0] q,
	output logic [1:0] strobe,
	output logic [0:0] valid
);
	initial begin
		dq = '0;
		q = '0;
		strobe = '0;
		valid = '0;
	end
	// one beat, then a strobe edge per group
	task automatic beat(input logic [17:0] d, input logic s);
		dq = d;
		q = d;
		repeat (3) @(negedge clock);
		strobe = {2{s}};
		repeat (3) @(negedge clock);
	endtask : beat
	// four beats, valid flag over the burst
	task automatic burst(input logic [71:0] data);
		valid = 1'b1;
		for (int i = 0; i < 4; i++) begin
			beat(data[i*18 +: 18], ~i[0]);
		end
		valid = 1'b0;
		dq = ~dq;
		q = ~q;
	endtask : burst
endmodule : mem_model

//--- testbench/low_latency_dram_datapath_tb.sv
`timescale 1ns/1ps
`define check_eq(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module low_latency_dram_datapath_tb;
	logic clock, nrst, init_done, read_burst_end;
	logic ctl_cs_n, ctl_we_n, ctl_ref_n, ctl_doing_wr, ctl_wdata_valid;
	logic [19:0] ctl_addr, mem_addr_0, mem_addr_1, mode_word;
	logic [2:0] ctl_bank, mem_bank_0, mem_bank_1;
	logic [35:0] ctl_wdata, rdata, last_word;
	logic [1:0] ctl_write_mask, mem_read_strobe_in, mem_read_strobe_out;
	logic [0:0] rdata_valid, mem_clk, mem_clk_n, mem_read_valid, mem_write_mask;
	logic mem_cs_n_0, mem_we_n_0, mem_ref_n_0, mem_cs_n_1, mem_we_n_1, mem_ref_n_1;
	logic [17:0] mem_dq_in, mem_dq_out, mem_q, mem_d;
	logic mem_dq_oe, mem_d_oe, mem_read_strobe_oe;
	int failures, checked, words, ends;
	low_latency_dram_datapath #(.INIT_CYCLES(16)) uut (
		.clock(clock),
		.nrst(nrst),
		.ctl_addr(ctl_addr),
		.ctl_bank(ctl_bank),
		.ctl_cs_n(ctl_cs_n),
		.ctl_we_n(ctl_we_n),
		.ctl_ref_n(ctl_ref_n),
		.ctl_doing_wr(ctl_doing_wr),
		.ctl_wdata_valid(ctl_wdata_valid),
		.ctl_wdata(ctl_wdata),
		.ctl_write_mask(ctl_write_mask),
		.init_done(init_done),
		.rdata(rdata),
		.rdata_valid(rdata_valid),
		.read_burst_end(read_burst_end),
		.mem_clk(mem_clk),
		.mem_clk_n(mem_clk_n),
		.mem_addr_0(mem_addr_0),
		.mem_bank_0(mem_bank_0),
		.mem_cs_n_0(mem_cs_n_0),
		.mem_we_n_0(mem_we_n_0),
		.mem_ref_n_0(mem_ref_n_0),
		.mem_addr_1(mem_addr_1),
		.mem_bank_1(mem_bank_1),
		.mem_cs_n_1(mem_cs_n_1),
		.mem_we_n_1(mem_we_n_1),
		.mem_ref_n_1(mem_ref_n_1),
		.mem_dq_in(mem_dq_in),
		.mem_dq_out(mem_dq_out),
		.mem_dq_oe(mem_dq_oe),
		.mem_q(mem_q),
		.mem_d(mem_d),
		.mem_d_oe(mem_d_oe),
		.mem_read_strobe_in(mem_read_strobe_in),
		.mem_read_strobe_out(mem_read_strobe_out),
		.mem_read_strobe_oe(mem_read_strobe_oe),
		.mem_read_valid(mem_read_valid),
		.mem_write_mask(mem_write_mask)
	);
	mem_model mem (.clock(clock), .dq(mem_dq_in), .q(mem_q), .strobe(mem_read_strobe_in),
		.valid(mem_read_valid));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// read word and mode word monitor
	always @(posedge clock) begin
		if (rdata_valid[0] === 1'b1) begin
			words++;
			last_word = rdata;
		end
		if (read_burst_end === 1'b1) ends++;
		if (init_done !== 1'b1 && mem_cs_n_0 === 1'b0 && mem_ref_n_0 === 1'b0)
			mode_word = mem_addr_0;
	end
	task end_of_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task reset_test;
		nrst = 1'b0;
		{ctl_cs_n, ctl_we_n, ctl_ref_n} = 3'h7;
		{ctl_doing_wr, ctl_wdata_valid} = 2'h0;
		ctl_addr = '0;
		ctl_bank = '0;
		ctl_wdata = '0;
		ctl_write_mask = '0;
		repeat (10) @(negedge clock);
		`check_eq("cs0", 1'b1, mem_cs_n_0)
		`check_eq("cs1", 1'b1, mem_cs_n_1)
		`check_eq("clk_n", 1'b1, mem_clk_n[0])
		repeat (10) @(negedge clock);
		nrst = 1'b1;
		for (int i = 0; i < 200 && init_done !== 1'b1; i++) @(negedge clock);
		`check_eq("init_done", 1'b1, init_done)
		`check_eq("mode", 20'h0_0089, mode_word)
		$display("reset test done");
	endtask : reset_test
	task cmd_test;
		@(negedge clock);
		if (mem_clk[0] !== 1'b0) @(negedge clock);
		{ctl_cs_n, ctl_we_n} = 2'h0;
		ctl_addr = 20'hA_5C3F;
		ctl_bank = 3'h5;
		@(negedge clock);
		{ctl_cs_n, ctl_we_n} = 2'h3;
		ctl_addr = '0;
		ctl_bank = '0;
		`check_eq("clk", 1'b1, mem_clk[0])
		`check_eq("clk_n", 1'b0, mem_clk_n[0])
		`check_eq("cs0", 1'b0, mem_cs_n_0)
		`check_eq("we0", 1'b0, mem_we_n_0)
		`check_eq("ref0", 1'b1, mem_ref_n_0)
		`check_eq("addr0", 20'hA_5C3F, mem_addr_0)
		`check_eq("bank0", 3'h5, mem_bank_0)
		`check_eq("cs1", 1'b1, mem_cs_n_1)
		@(negedge clock);
		`check_eq("cs0 held", 1'b0, mem_cs_n_0)
		@(negedge clock);
		`check_eq("cs0 idle", 1'b1, mem_cs_n_0)
		$display("command test done");
	endtask : cmd_test
	task wr_test;
		@(negedge clock);
		ctl_wdata_valid = 1'b1;
		ctl_doing_wr = 1'b1;
		ctl_wdata = {18'h2_BCDE, 18'h1_2345};
		ctl_write_mask = 2'h2;
		@(negedge clock);
		ctl_wdata_valid = 1'b0;
		ctl_wdata = ~ctl_wdata;
		ctl_write_mask = 2'h1;
		repeat (3) @(negedge clock);
		repeat (2) begin
			`check_eq("dq_oe", 1'b1, mem_dq_oe)
			`check_eq("d_oe", 1'b0, mem_d_oe)
			`check_eq("dq", mem_clk[0] ? 18'h1_2345 : 18'h2_BCDE, mem_dq_out)
			`check_eq("mask", ~mem_clk, mem_write_mask)
			@(negedge clock);
		end
		ctl_doing_wr = 1'b0;
		repeat (2) @(negedge clock);
		`check_eq("dq_oe off", 1'b0, mem_dq_oe)
		$display("write test done");
	endtask : wr_test
	task rd_test;
		words = 0;
		ends = 0;
		mem.burst({18'h3_0004, 18'h0_0C03, 18'h2_0B02, 18'h1_0A01});
		repeat (6) @(negedge clock);
		`check_eq("words", 2, words)
		`check_eq("burst end", 1, ends)
		`check_eq("rdata", {18'h3_0004, 18'h0_0C03}, last_word)
		$display("read test done");
	endtask : rd_test
	initial begin
		repeat (2000) @(posedge clock);
		failures++;
		end_of_test();
	end
	initial begin
		reset_test();
		cmd_test();
		wr_test();
		rd_test();
		end_of_test();
	end
endmodule : low_latency_dram_datapath_tb
